// >>> src/bsd_map.svh
// Register offsets, field positions, reset values and mode codes
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH
`define BSD_OFF_CTRL      8'h00
`define BSD_OFF_SWEN      8'h04
`define BSD_OFF_POL       8'h08
`define BSD_OFF_MEAS      8'h0C
`define BSD_OFF_DIAG      8'h10
`define BSD_OFF_THR       8'h14
`define BSD_OFF_STAT      8'h18
`define BSD_CTRL_MODE_LSB 0
`define BSD_CTRL_ALT_BIT  3
`define BSD_CTRL_OVS_LSB  4
`define BSD_CTRL_GO_BIT   7
`define BSD_CTRL_TOP1_LSB 8
`define BSD_CTRL_TOP2_LSB 12
`define BSD_MEAS_AUX_LSB  16
`define BSD_THR_HI_LSB    16
`define BSD_STAT_SUM_BIT  16
`define BSD_STAT_BUSY_BIT 17
`define BSD_STAT_DONE_BIT 18
`define BSD_RST_CTRL      32'h0000_EE00
`define BSD_RST_THR       32'h3FFF_0000
`define BSD_MODE_SHORT    3'h4
`define BSD_MODE_OPEN     3'h5
`define BSD_MODE_ODD      3'h6
`define BSD_MODE_EVEN     3'h7
`define BSD_PAT_ODD       14'h1555
`define BSD_PAT_EVEN      14'h2AAA
`define BSD_NUM_CELLS     14
`define BSD_RESP_OKAY     2'h0
`define BSD_RESP_SLVERR   2'h2
`endif

// >>> src/bsd_pkg.sv
// Types shared by the switch diagnostic sequencer
package bsd_pkg;
    typedef enum {BSD_IDLE, BSD_RUN} bsd_state_e;
    typedef logic [13:0] bsd_chan_t;
    // Acquisition settings handed to the measurement engine
    typedef struct packed {
        logic [15:0] cell_measure_enables;
        logic [5:0]  aux_measure_enables;
        bsd_chan_t   balance_switch_enable;
        logic [15:0] diagnostic_selectors;
        logic        alternate_path_select;
        logic [2:0]  oversample_rate;
        logic        bipolar_mode;
    } bsd_acq_cfg_s;
    // One channel result from the measurement engine
    typedef struct packed {
        logic        valid;
        logic [3:0]  channel;
        logic [13:0] data;
    } bsd_result_s;
endpackage : bsd_pkg

// >>> src/bsd_top.sv
// Switch-open and sense-wire-open scan sequencer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "bsd_map.svh"

module bsd_top
    import bsd_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [7:0]   s_awaddr,
    input  wire logic         s_awvalid,
    output logic              s_awready,
    input  wire logic [31:0]  s_wdata,
    input  wire logic [3:0]   s_wstrb,
    input  wire logic         s_wvalid,
    output logic              s_wready,
    output logic [1:0]        s_bresp,
    output logic              s_bvalid,
    input  wire logic         s_bready,
    input  wire logic [7:0]   s_araddr,
    input  wire logic         s_arvalid,
    output logic              s_arready,
    output logic [31:0]       s_rdata,
    output logic [1:0]        s_rresp,
    output logic              s_rvalid,
    input  wire logic         s_rready,
    output bsd_acq_cfg_s      acq_cfg,
    output logic              scan_start,
    input  wire bsd_result_s  meas_result,
    input  wire logic         scan_done
);

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Positions at or below a top cell setting (bit i is cell i+1)
    function automatic bsd_chan_t below_top(input logic [3:0] top);
        bsd_chan_t m;
        for (int i = 0; i < `BSD_NUM_CELLS; i++) begin
            m[i] = (5'(i) < {1'b0, top});
        end
        return m;
    endfunction : below_top

    logic [31:0]  ctrl_q, swen_q, pol_q, meas_q, diag_q, thr_q;
    bsd_chan_t    flags_q, pend_q;
    logic         sum_q, done_q;
    bsd_state_e   state_q;
    logic [2:0]   mode_q;
    logic [7:0]   awaddr_q;
    logic [31:0]  wdata_q;
    logic [3:0]   wstrb_q;
    logic         aw_full_q, w_full_q, wr_en, start_req;
    logic         run, m_open, m_wire, m_bal, cmp_on, top_eq;
    bsd_chan_t    tmask, forced_pat, res_flags;
    bsd_acq_cfg_s user_cfg, acq_d, acq_q;
    logic [13:0]  thr_lo, thr_hi;

    assign wr_en     = aw_full_q && w_full_q && !s_bvalid;
    assign run       = (state_q == BSD_RUN);
    assign m_open    = (mode_q == `BSD_MODE_OPEN);
    assign m_wire    = (mode_q == `BSD_MODE_ODD) || (mode_q == `BSD_MODE_EVEN);
    assign m_bal     = mode_q[2];
    assign cmp_on    = run && (m_open || m_wire);
    assign thr_lo    = thr_q[13:0];
    assign thr_hi    = thr_q[`BSD_THR_HI_LSB +: 14];
    // Start only on a host write of the go bit while idle
    assign start_req = wr_en && (awaddr_q == `BSD_OFF_CTRL) && wstrb_q[0]
                       && wdata_q[`BSD_CTRL_GO_BIT] && !run;
    // Differing top settings leave every flag visible
    assign top_eq    = ctrl_q[`BSD_CTRL_TOP1_LSB +: 4] == ctrl_q[`BSD_CTRL_TOP2_LSB +: 4];
    assign tmask     = top_eq ? below_top(ctrl_q[`BSD_CTRL_TOP1_LSB +: 4]) : '1;
    assign res_flags = pend_q & tmask;

    // Write address and data are caught independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            s_awready <= s_awvalid && !s_awready && !aw_full_q && !s_bvalid;
            s_wready  <= s_wvalid && !s_wready && !w_full_q && !s_bvalid;
            if (s_awvalid && s_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q  <= s_awaddr;
            end else if (wr_en) begin
                aw_full_q <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_full_q <= 1'b1;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
            end else if (wr_en) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_bvalid <= 1'b0;
            s_bresp  <= `BSD_RESP_OKAY;
        end else if (wr_en) begin
            s_bvalid <= 1'b1;
            s_bresp  <= (awaddr_q > `BSD_OFF_STAT || awaddr_q[1:0] != 2'h0)
                        ? `BSD_RESP_SLVERR : `BSD_RESP_OKAY;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // User configuration registers; the go bit is not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `BSD_RST_CTRL;
            swen_q <= 32'h0000_0000;
            pol_q  <= 32'h0000_0000;
            meas_q <= 32'h0000_0000;
            diag_q <= 32'h0000_0000;
            thr_q  <= `BSD_RST_THR;
        end else if (wr_en) begin
            unique case (awaddr_q)
                `BSD_OFF_CTRL: ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_FF7F;
                `BSD_OFF_SWEN: swen_q <= merge(swen_q, wdata_q, wstrb_q) & 32'h0000_3FFF;
                `BSD_OFF_POL:  pol_q  <= merge(pol_q, wdata_q, wstrb_q) & 32'h0000_3FFF;
                `BSD_OFF_MEAS: meas_q <= merge(meas_q, wdata_q, wstrb_q) & 32'h003F_FFFF;
                `BSD_OFF_DIAG: diag_q <= merge(diag_q, wdata_q, wstrb_q) & 32'h0000_FFFF;
                `BSD_OFF_THR:  thr_q  <= merge(thr_q, wdata_q, wstrb_q) & 32'h3FFF_3FFF;
                default: ;
            endcase
        end
    end

    // Scan sequencer: latches the mode at the request, ends on engine done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= BSD_IDLE;
            mode_q     <= 3'h0;
            scan_start <= 1'b0;
        end else begin
            scan_start <= start_req;
            unique case (state_q)
                BSD_IDLE: if (start_req) begin
                    state_q <= BSD_RUN;
                    mode_q  <= ctrl_q[`BSD_CTRL_MODE_LSB +: 3];
                end
                BSD_RUN: if (scan_done) begin
                    state_q <= BSD_IDLE;
                end
            endcase
        end
    end

    // Forced pattern keeps only unipolar positions at or below top
    always_comb begin
        forced_pat = (mode_q == `BSD_MODE_ODD) ? `BSD_PAT_ODD : `BSD_PAT_EVEN;
        forced_pat = forced_pat & ~pol_q[13:0]
                     & below_top(ctrl_q[`BSD_CTRL_TOP1_LSB +: 4]);
    end

    // Effective acquisition settings: user values unless a scan overrides
    always_comb begin
        user_cfg.cell_measure_enables  = meas_q[15:0];
        user_cfg.aux_measure_enables   = meas_q[`BSD_MEAS_AUX_LSB +: 6];
        user_cfg.balance_switch_enable = swen_q[13:0];
        user_cfg.diagnostic_selectors  = diag_q[15:0];
        user_cfg.alternate_path_select = ctrl_q[`BSD_CTRL_ALT_BIT];
        user_cfg.oversample_rate       = ctrl_q[`BSD_CTRL_OVS_LSB +: 3];
        user_cfg.bipolar_mode          = 1'b0;
        acq_d = user_cfg;
        if (cmp_on) begin
            acq_d.cell_measure_enables[15:14] = 2'h0;
            acq_d.aux_measure_enables         = 6'h00;
            acq_d.diagnostic_selectors        = 16'h0000;
            acq_d.alternate_path_select       = 1'b1;
            acq_d.oversample_rate             = 3'h0;
            acq_d.bipolar_mode                = 1'b1;
            if (m_wire) begin
                acq_d.balance_switch_enable       = forced_pat;
                acq_d.cell_measure_enables[13:0]  = forced_pat & ~pol_q[13:0];
            end else begin
                // Manual balancing need not be running; enables pick targets
                acq_d.cell_measure_enables[13:0]  = swen_q[13:0] & ~pol_q[13:0];
            end
        end
    end

    // Registered so the engine sees glitch-free settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acq_q <= '0;
        end else begin
            acq_q <= acq_d;
        end
    end
    assign acq_cfg = acq_q;

    // Per-channel threshold compare, accumulated over the scan
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= '0;
        end else if (start_req) begin
            pend_q <= '0;
        end else if (cmp_on && meas_result.valid && meas_result.channel < 4'hE) begin
            if (meas_result.data > thr_hi || meas_result.data < thr_lo) begin
                pend_q[meas_result.channel] <= 1'b1;
            end
        end
    end

    // Fault flags: in modes 4 to 7 cleared at request and loaded at end, the end winning over a summary clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= '0;
            sum_q   <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            if (start_req && ctrl_q[`BSD_CTRL_MODE_LSB + 2]) begin
                flags_q <= '0;
            end
            if (wr_en && awaddr_q == `BSD_OFF_STAT && wstrb_q[2]) begin
                if (!wdata_q[`BSD_STAT_SUM_BIT]) begin
                    sum_q <= 1'b0;
                end
                if (wdata_q[`BSD_STAT_DONE_BIT]) begin
                    done_q <= 1'b0;
                end
            end
            if (run && scan_done) begin
                done_q <= 1'b1;
                if (m_bal) begin
                    flags_q <= res_flags;
                    sum_q   <= |res_flags;
                end
            end
        end
    end

    // Read channel: one read at a time, answer registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0000_0000;
            s_rresp   <= `BSD_RESP_OKAY;
        end else begin
            s_arready <= s_arvalid && !s_arready && !s_rvalid;
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp  <= `BSD_RESP_OKAY;
                unique case (s_araddr)
                    `BSD_OFF_CTRL: s_rdata <= ctrl_q;
                    `BSD_OFF_SWEN: s_rdata <= swen_q;
                    `BSD_OFF_POL:  s_rdata <= pol_q;
                    `BSD_OFF_MEAS: s_rdata <= meas_q;
                    `BSD_OFF_DIAG: s_rdata <= diag_q;
                    `BSD_OFF_THR:  s_rdata <= thr_q;
                    `BSD_OFF_STAT: s_rdata <= {13'h0000, done_q, run, sum_q, 2'h0, flags_q};
                    default: begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= `BSD_RESP_SLVERR;
                    end
                endcase
            end else if (s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // Checks on the override, compare and result paths
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_open_path;
        run && m_open |=> acq_q.alternate_path_select && acq_q.bipolar_mode;
    endproperty
    a_open_path: assert property (p_open_path) else $error("open scan path wrong");

    property p_open_cells;
        run && m_open |=> acq_q.cell_measure_enables[13:0] == ($past(swen_q[13:0])
                                                               & ~$past(pol_q[13:0]));
    endproperty
    a_open_cells: assert property (p_open_cells) else $error("open scan cells wrong");

    property p_open_zero;
        run && m_open |=> acq_q.cell_measure_enables[15:14] == 2'h0
            && acq_q.aux_measure_enables == 6'h00 && acq_q.diagnostic_selectors == 16'h0000;
    endproperty
    a_open_zero: assert property (p_open_zero) else $error("open scan not zeroed");

    property p_one_sample;
        cmp_on |=> acq_q.oversample_rate == 3'h0 && acq_q.alternate_path_select;
    endproperty
    a_one_sample: assert property (p_one_sample) else $error("oversample kept");

    property p_odd_pat;
        run && mode_q == `BSD_MODE_ODD |=> (acq_q.balance_switch_enable & `BSD_PAT_EVEN) == '0;
    endproperty
    a_odd_pat: assert property (p_odd_pat) else $error("even switch in odd scan");

    property p_wire_cells;
        run && m_wire |=> acq_q.cell_measure_enables[13:0]
            == (acq_q.balance_switch_enable & ~$past(pol_q[13:0]));
    endproperty
    a_wire_cells: assert property (p_wire_cells) else $error("sense cells wrong");

    property p_restore;
        !run ##1 !run |-> acq_q == $past(user_cfg);
    endproperty
    a_restore: assert property (p_restore) else $error("config not restored");

    property p_flags_end;
        run && scan_done && m_bal |=> flags_q == $past(res_flags);
    endproperty
    a_flags_end: assert property (p_flags_end) else $error("flags not loaded");

    property p_summary;
        run && scan_done && m_bal |=> sum_q == (flags_q != '0);
    endproperty
    a_summary: assert property (p_summary) else $error("summary wrong");

    property p_no_self;
        $rose(scan_start) |-> $past(start_req);
    endproperty
    a_no_self: assert property (p_no_self) else $error("scan self-started");

    c_open_fault: cover property (run && m_open && scan_done && res_flags != '0);
    c_odd_scan:   cover property (run && mode_q == `BSD_MODE_ODD && scan_done);
    c_even_scan:  cover property (run && mode_q == `BSD_MODE_EVEN && scan_done);

endmodule : bsd_top
`default_nettype wire

// >>> verification/bsd_engine_model.sv
// Measurement engine stand-in that answers scan requests from the sequencer
`timescale 1ns/1ps
`default_nettype none
module bsd_engine_model
    import bsd_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire bsd_acq_cfg_s acq_cfg,
    input  wire logic         scan_start,
    input  wire logic [13:0]  volt [14],
    input  wire logic         slow,
    output bsd_result_s       meas_result,
    output logic              scan_done,
    output bsd_acq_cfg_s      cfg_seen,
    output logic [7:0]        scan_cnt
);
    // One channel slot per cell, results only where the effective enables allow
    initial begin
        meas_result = '0;
        scan_done = 1'b0;
        cfg_seen = '0;
        scan_cnt = 8'h00;
        forever begin
            @(posedge aclk);
            if (aresetn && scan_start) begin
                scan_cnt <= scan_cnt + 8'h01;
                repeat (3) @(posedge aclk);
                cfg_seen <= acq_cfg;
                for (int c = 0; c < 14; c++) begin
                    @(posedge aclk);
                    meas_result <= '{acq_cfg.cell_measure_enables[c], 4'(c), volt[c]};
                    if (slow) begin
                        @(posedge aclk);
                        // Idle slots carry flipped data so a stale value never looks valid
                        meas_result <= '{1'b0, 4'hF, ~volt[c]};
                    end
                end
                @(posedge aclk);
                meas_result <= '{1'b0, 4'hF, ~meas_result.data};
                scan_done <= 1'b1;
                @(posedge aclk);
                scan_done <= 1'b0;
            end
        end
    end
endmodule : bsd_engine_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the switch diagnostic sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bsd_map.svh"
module testbench
    import bsd_pkg::*;
;
    logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
    logic [7:0]   awaddr, araddr, scan_cnt;
    logic [31:0]  wdata, rdata;
    logic         awready, wready, bvalid, arready, rvalid, scan_start, scan_done;
    logic [1:0]   bresp, rresp, last_b;
    bsd_acq_cfg_s acq_cfg, cfg_seen, ucfg;
    bsd_result_s  meas_result;
    logic [13:0]  volt [14];
    int           fails, n_compared;

    bsd_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .acq_cfg(acq_cfg),
        .scan_start(scan_start), .meas_result(meas_result), .scan_done(scan_done));
    bsd_engine_model eng (.aclk(aclk), .aresetn(aresetn), .acq_cfg(acq_cfg),
        .scan_start(scan_start), .volt(volt), .slow(slow), .meas_result(meas_result),
        .scan_done(scan_done), .cfg_seen(cfg_seen), .scan_cnt(scan_cnt));

    // 10 MHz clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Write cycle; each channel is released at the edge that takes it
    // Waits as long as the slave needs; only the watchdog ends a hung wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        last_b = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // Select the mode, settle, start, wait for idle and judge the outcome
    task automatic run_scan(input logic [15:0] ctrl, input logic [13:0] en, fl);
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] c0;
        bsd_acq_cfg_s e;
        c0 = scan_cnt;
        wr(`BSD_OFF_CTRL, {16'h0000, ctrl});
        repeat (1000) @(posedge aclk); // settling time after mode select
        chk("no self start", scan_cnt, c0);
        wr(`BSD_OFF_CTRL, {16'h0000, ctrl | 16'h0080});
        rd(`BSD_OFF_STAT, d, r);
        chk("flags at request", d & 32'h0002_3FFF, 32'h0002_0000);
        // Poll until idle; a scan that never ends is caught by the watchdog
        do begin
            rd(`BSD_OFF_STAT, d, r);
        end while (d[17] !== 1'b0);
        e = '0;
        e.cell_measure_enables = {2'b00, en};
        e.balance_switch_enable = (ctrl[2:0] == 3'h5) ? ucfg.balance_switch_enable : en;
        e.alternate_path_select = 1'b1;
        e.bipolar_mode = 1'b1;
        chk("override", cfg_seen, e);
        chk("status", d, {13'h0000, 3'b100 | {2'b00, |fl} , 2'b00, fl});
        repeat (2) @(posedge aclk);
        e = ucfg;
        e.alternate_path_select = ctrl[3];
        e.oversample_rate = ctrl[6:4];
        chk("restored", acq_cfg, e);
    endtask : run_scan

    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        chk("cfg at reset", acq_cfg, 64'h0);
        rd(`BSD_OFF_CTRL, d, r);
        chk("ctrl reset", d, `BSD_RST_CTRL);
        rd(`BSD_OFF_THR, d, r);
        chk("thr reset", d, `BSD_RST_THR);
        rd(8'h1C, d, r);
        chk("unmapped read", {r, d}, {`BSD_RESP_SLVERR, 32'h0});
        wr(8'h1C, 32'hFFFF_FFFF);
        chk("unmapped write", last_b, `BSD_RESP_SLVERR);
    endtask : t_reset

    task automatic t_open;
        wr(`BSD_OFF_SWEN, 32'h0000_30FC);
        wr(`BSD_OFF_POL, 32'h0000_0003);
        wr(`BSD_OFF_MEAS, 32'h003F_FFFF);
        wr(`BSD_OFF_DIAG, 32'h0000_1234);
        wr(`BSD_OFF_THR, 32'h0200_0100);
        ucfg = '{16'hFFFF, 6'h3F, 14'h30FC, 16'h1234, 1'b0, 3'h0, 1'b0};
        volt[2] <= 14'h0050;
        volt[4] <= 14'h0300;
        volt[5] <= 14'h0100;
        volt[6] <= 14'h0200;
        volt[8] <= 14'h0300;
        volt[12] <= 14'h0300;
        volt[13] <= 14'h0300;
        run_scan(16'hCC35, 14'h30FC, 14'h0014); // equal tops mask 13,14
        slow <= 1'b1;
        run_scan(16'hEC3D, 14'h30FC, 14'h3014); // unequal tops mask nothing
    endtask : t_open

    task automatic t_sense;
        logic [31:0] d;
        logic [1:0] r;
        wr(`BSD_OFF_POL, 32'h0000_0010);
        slow <= 1'b0;
        volt[0] <= 14'h0050;
        volt[1] <= 14'h0300;
        volt[2] <= 14'h0150;
        volt[6] <= 14'h0150;
        volt[8] <= 14'h0150;
        volt[13] <= 14'h0050;
        run_scan(16'hCC06, 14'h0545, 14'h0001); // busbar, top masked
        run_scan(16'hCC07, 14'h0AAA, 14'h0002); // even pattern
        // Clearing summary and done must leave the last flags in place
        wr(`BSD_OFF_STAT, 32'h0004_0000);
        chk("status write", last_b, `BSD_RESP_OKAY);
        rd(`BSD_OFF_STAT, d, r);
        chk("flags kept", d, 32'h0000_0002);
    endtask : t_sense

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        fails = 0;
        n_compared = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        ucfg = '0;
        foreach (volt[i]) volt[i] = 14'h0150;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_open();
        t_sense();
        print_verdict();
    end

    // Watchdog well beyond the four scans of about 1050 cycles each
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
